/* logic/mrc_pkg.sv */
// Constants, field layout and carrier types for the receive config / management register slice.
// Assumes an 8-bit register port on the core clock and a receive engine reporting frame results.
// Contract
// - Receive config bit 6 sets interrupt polarity, sense reversed in non-ISA bus modes, reset 1.
// - Bit 5 set: frames checked on address and CRC but never written to buffer.
// - Bit 4 set: accept every frame with individual destination address.
// - Bit 2 set accepts broadcast frames; clear rejects them.
// - Bit 1 set accepts runt frames instead of discarding them.
// - Bit 0 set accepts and stores frames received with errors.
// - Write to 0CH loads receive config; read of 0CH returns receive status.
// - Receive status bits: 6 disabled, 5 multicast, 4 missed, 3 overrun, 2 align, 1 CRC, 0 intact.
// - Inter-frame gap at 16H, 7-bit read/write, reset 15H, bit 7 reserved.
// - Gap segment one at 12H, 7-bit read/write, reset 0cH.
// - Gap segment two at 13H, 7-bit read/write, reset 12H.
// - Management bit 6 is read-only synchronized level of ROM data output pin.
// - Management bits 5, 7, 4 drive ROM data in, clock, select directly.
// - Management bit 3 driven onto MDIO only while direction bit is 0.
// - Management bit 2 is read-only sampled MDIO level.
// - Bit 1 set releases MDIO as input, clear drives it; host sets before reading.
// - Management bit 0 drives the MDC pin directly.
// - Read of 15H returns PHY status: bit 3 fast, bit 2 slow, bit 1 whole PHY in reset.
// - Status bit 0 rises on negotiation done, drops when negotiation restarts.
package mrc_pkg;
  localparam logic [4:0] MRC_OFF_RX_CFG   = 5'h0c;
  localparam logic [4:0] MRC_OFF_GAP_ONE  = 5'h12;
  localparam logic [4:0] MRC_OFF_GAP_TWO  = 5'h13;
  localparam logic [4:0] MRC_OFF_MGMT     = 5'h14;
  localparam logic [4:0] MRC_OFF_TEST     = 5'h15;
  localparam logic [4:0] MRC_OFF_GAP      = 5'h16;
  localparam logic [7:0] MRC_RST_RX_CFG   = 8'h40;
  localparam logic [6:0] MRC_RST_GAP      = 7'h15;
  localparam logic [6:0] MRC_RST_GAP_ONE  = 7'h0c;
  localparam logic [6:0] MRC_RST_GAP_TWO  = 7'h12;
  localparam logic [7:0] MRC_RST_MGMT     = 8'h02;
  localparam logic [4:0] MRC_RST_TEST     = 5'h00;
  localparam int         MRC_B_POL        = 6;
  localparam int         MRC_B_MON        = 5;
  localparam int         MRC_B_PRO        = 4;
  localparam int         MRC_B_GRP        = 3;
  localparam int         MRC_B_BC         = 2;
  localparam int         MRC_B_RUNT       = 1;
  localparam int         MRC_B_ERR        = 0;
  localparam int         MRC_B_RCLK       = 7;
  localparam int         MRC_B_RDO        = 6;
  localparam int         MRC_B_RDI        = 5;
  localparam int         MRC_B_RCS        = 4;
  localparam int         MRC_B_MDO        = 3;
  localparam int         MRC_B_MDI        = 2;
  localparam int         MRC_B_MGMT_DIR_BIT       = 1;
  localparam int         MRC_B_MDC        = 0;

  typedef struct packed {
    logic keep_errored_frames;
    logic accept_short_frames;
    logic accept_bcast;
    logic accept_group_cast;
    logic accept_all_unicast;
    logic watch_only_mode;
  } mrc_filt_t;

  typedef struct packed {
    logic rx_off_flag;
    logic group_addr_seen;
    logic lost_frame_flag;
    logic rx_overflow_flag;
    logic misaligned_frame_flag;
    logic checksum_bad_flag;
    logic rx_intact_flag;
  } mrc_rxst_t;

  typedef struct packed {
    logic fast_phy_in_reset;
    logic slow_phy_in_reset;
    logic phy_busy_reset;
    logic negotiation_done;
  } mrc_physt_t;
endpackage : mrc_pkg

/* logic/mrc_regs.sv */
// Register slice: receive config/status, gap timers, ROM and management bit port, test register.
// Assumes host strobes are one-cycle pulses on clk; pins and PHY status are asynchronous.
`timescale 1ns/10ps
module mrc_regs
  import mrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  addr,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  input  wire logic        isa_bus_mode,
  input  wire logic        irq_raw,
  output logic             irq_pin,
  input  wire logic        frm_end,
  input  wire mrc_rxst_t   frm_status,
  input  wire logic        frm_unicast,
  input  wire logic        frm_station_hit,
  input  wire logic        frm_multicast,
  input  wire logic        frm_hash_hit,
  input  wire logic        frm_bcast,
  input  wire logic        frm_runt,
  input  wire logic        frm_errored,
  output logic             frm_accept,
  output logic             frm_store,
  output mrc_filt_t        filt_cfg,
  output logic      [6:0]  gap_length,
  output logic      [6:0]  gap_seg_one,
  output logic      [6:0]  gap_seg_two,
  output logic             serial_rom_clock,
  output logic             serial_rom_select,
  output logic             rom_data_in_pin,
  input  wire logic        rom_data_out_pin,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  output logic             mdc_pin,
  output logic      [4:0]  test_ctrl,
  input  wire mrc_physt_t  phy_status
);

  logic [7:0] rx_cfg_ff;
  mrc_rxst_t  rx_stat_ff;
  logic [6:0] gap_ff;
  logic [6:0] gap_one_ff;
  logic [6:0] gap_two_ff;
  logic [7:0] mgmt_ff;
  logic [4:0] test_ff;
  logic [7:0] rd_data_ff;
  logic       rd_valid_ff;
  logic [1:0] rdo_sync_ff;
  logic [1:0] mdi_sync_ff;
  logic [3:0] phy_sync0_ff;
  logic [3:0] phy_sync1_ff;
  logic       irq_ff;
  logic       addr_ok;
  logic [7:0] nxt_rd_data;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_cfg_ff <= MRC_RST_RX_CFG;
    else if (wr_stb && hit(addr, MRC_OFF_RX_CFG))
      rx_cfg_ff <= {1'b0, wr_data[6:0]};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gap_ff     <= MRC_RST_GAP;
      gap_one_ff <= MRC_RST_GAP_ONE;
      gap_two_ff <= MRC_RST_GAP_TWO;
    end
    else if (wr_stb)
    begin
      if (hit(addr, MRC_OFF_GAP))
        gap_ff <= wr_data[6:0];
      if (hit(addr, MRC_OFF_GAP_ONE))
        gap_one_ff <= wr_data[6:0];
      if (hit(addr, MRC_OFF_GAP_TWO))
        gap_two_ff <= wr_data[6:0];
    end
  end

  // stored port bits
  // MDIO released at reset so the pin never fights the PHY
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mgmt_ff <= MRC_RST_MGMT;
    else if (wr_stb && hit(addr, MRC_OFF_MGMT))
      mgmt_ff <= wr_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      test_ff <= MRC_RST_TEST;
    else if (wr_stb && hit(addr, MRC_OFF_TEST))
      test_ff <= wr_data[4:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_stat_ff <= '0;
    else if (frm_end)
      rx_stat_ff <= frm_status;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdo_sync_ff  <= 2'h0;
      mdi_sync_ff  <= 2'h0;
      phy_sync0_ff <= 4'h0;
      phy_sync1_ff <= 4'h0;
    end
    else
    begin
      rdo_sync_ff  <= {rdo_sync_ff[0], rom_data_out_pin};
      mdi_sync_ff  <= {mdi_sync_ff[0], mdio_i};
      phy_sync0_ff <= phy_status;
      phy_sync1_ff <= phy_sync0_ff;
    end
  end

  always_comb
  begin
    addr_ok     = 1'b1;
    nxt_rd_data = 8'h00;
    if (hit(addr, MRC_OFF_RX_CFG))
      nxt_rd_data = {1'b0, rx_stat_ff};
    else if (hit(addr, MRC_OFF_GAP_ONE))
      nxt_rd_data = {1'b0, gap_one_ff};
    else if (hit(addr, MRC_OFF_GAP_TWO))
      nxt_rd_data = {1'b0, gap_two_ff};
    else if (hit(addr, MRC_OFF_MGMT))
      nxt_rd_data = {mgmt_ff[7], rdo_sync_ff[1], mgmt_ff[5:3], mdi_sync_ff[1], mgmt_ff[1:0]};
    else if (hit(addr, MRC_OFF_TEST))
      nxt_rd_data = {4'h0, phy_sync1_ff};
    else if (hit(addr, MRC_OFF_GAP))
      nxt_rd_data = {1'b0, gap_ff};
    else
      addr_ok = 1'b0;
  end

  // Unmapped reads answer zero but still complete
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_stb;
      if (rd_stb)
        rd_data_ff <= addr_ok ? nxt_rd_data : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= irq_raw ^ ~(rx_cfg_ff[MRC_B_POL] ~^ isa_bus_mode);
  end

  always_comb
  begin
    frm_accept = 1'b0;
    if (frm_unicast && (frm_station_hit || rx_cfg_ff[MRC_B_PRO]))
      frm_accept = 1'b1;
    if (frm_multicast && !frm_bcast && rx_cfg_ff[MRC_B_GRP] && frm_hash_hit)
      frm_accept = 1'b1;
    if (frm_bcast && rx_cfg_ff[MRC_B_BC])
      frm_accept = 1'b1;
    if (frm_runt && !rx_cfg_ff[MRC_B_RUNT])
      frm_accept = 1'b0;
    if (frm_errored && !rx_cfg_ff[MRC_B_ERR])
      frm_accept = 1'b0;
  end

  assign frm_store = frm_accept && !rx_cfg_ff[MRC_B_MON];

  assign filt_cfg.keep_errored_frames = rx_cfg_ff[MRC_B_ERR];
  assign filt_cfg.accept_short_frames = rx_cfg_ff[MRC_B_RUNT];
  assign filt_cfg.accept_bcast        = rx_cfg_ff[MRC_B_BC];
  assign filt_cfg.accept_group_cast   = rx_cfg_ff[MRC_B_GRP];
  assign filt_cfg.accept_all_unicast  = rx_cfg_ff[MRC_B_PRO];
  assign filt_cfg.watch_only_mode     = rx_cfg_ff[MRC_B_MON];
  assign gap_length        = gap_ff;
  assign gap_seg_one       = gap_one_ff;
  assign gap_seg_two       = gap_two_ff;
  assign rd_data           = rd_data_ff;
  assign rd_valid          = rd_valid_ff;
  assign irq_pin           = irq_ff;
  assign test_ctrl         = test_ff;
  assign serial_rom_clock  = mgmt_ff[MRC_B_RCLK];
  assign serial_rom_select = mgmt_ff[MRC_B_RCS];
  assign rom_data_in_pin   = mgmt_ff[MRC_B_RDI];
  assign mdio_o            = mgmt_ff[MRC_B_MDO];
  assign mdio_oe           = !mgmt_ff[MRC_B_MGMT_DIR_BIT];
  assign mdc_pin           = mgmt_ff[MRC_B_MDC];

  property p_cfg_load;
    @(posedge clk) disable iff (rst)
    wr_stb && hit(addr, MRC_OFF_RX_CFG) |=> rx_cfg_ff[6:0] == $past(wr_data[6:0]);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");

  property p_stat_read;
    @(posedge clk) disable iff (rst)
    rd_stb && hit(addr, MRC_OFF_RX_CFG) && !frm_end |=> rd_data == {1'b0, rx_stat_ff} && rd_valid;
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");

  property p_stat_upd;
    @(posedge clk) disable iff (rst)
    frm_end |=> rx_stat_ff == $past(frm_status);
  endproperty
  a_stat_upd: assert property (p_stat_upd) else $error("status not updated");

  property p_mon;
    @(posedge clk) disable iff (rst)
    rx_cfg_ff[MRC_B_MON] |-> !frm_store;
  endproperty
  a_mon: assert property (p_mon) else $error("stored in monitor mode");

  property p_bc;
    @(posedge clk) disable iff (rst)
    frm_bcast && !frm_unicast && !rx_cfg_ff[MRC_B_BC] |-> !frm_accept;
  endproperty
  a_bc: assert property (p_bc) else $error("broadcast accepted");

  property p_err;
    @(posedge clk) disable iff (rst)
    frm_errored && !rx_cfg_ff[MRC_B_ERR] |-> !frm_accept;
  endproperty
  a_err: assert property (p_err) else $error("error frame accepted");

  property p_mdio;
    @(posedge clk) disable iff (rst)
    wr_stb && hit(addr, MRC_OFF_MGMT) |=> mdio_oe == !$past(wr_data[MRC_B_MGMT_DIR_BIT]) && mdio_o == $past(wr_data[3]);
  endproperty
  a_mdio: assert property (p_mdio) else $error("mdio drive wrong");

  property p_mdi;
    @(posedge clk) disable iff (rst)
    rd_stb && hit(addr, MRC_OFF_MGMT) |=> rd_data[MRC_B_MDI] == $past(mdi_sync_ff[1]);
  endproperty
  a_mdi: assert property (p_mdi) else $error("mdio sample wrong");

  property p_pol;
    @(posedge clk) disable iff (rst)
    $stable(irq_raw) && $stable(isa_bus_mode) && $stable(rx_cfg_ff[MRC_B_POL])
      |=> irq_pin == ($past(irq_raw) ^ ~($past(rx_cfg_ff[MRC_B_POL]) ~^ $past(isa_bus_mode)));
  endproperty
  a_pol: assert property (p_pol) else $error("irq polarity wrong");

  property p_gap;
    @(posedge clk) disable iff (rst)
    wr_stb && hit(addr, MRC_OFF_GAP) |=> gap_length == $past(wr_data[6:0]);
  endproperty
  a_gap: assert property (p_gap) else $error("gap not written");

  property p_uni;
    @(posedge clk) disable iff (rst)
    frm_unicast && rx_cfg_ff[MRC_B_PRO] && !frm_runt && !frm_errored |-> frm_accept;
  endproperty
  a_uni: assert property (p_uni) else $error("unicast dropped");

  property p_grp;
    @(posedge clk) disable iff (rst)
    frm_multicast && !frm_hash_hit && !frm_bcast && !frm_unicast |-> !frm_accept;
  endproperty
  a_grp: assert property (p_grp) else $error("unhashed multicast accepted");

  property p_runt;
    @(posedge clk) disable iff (rst)
    frm_runt && !rx_cfg_ff[MRC_B_RUNT] |-> !frm_accept;
  endproperty
  a_runt: assert property (p_runt) else $error("runt accepted");

  property p_gap_one;
    @(posedge clk) disable iff (rst)
    wr_stb && hit(addr, MRC_OFF_GAP_ONE) |=> gap_seg_one == $past(wr_data[6:0]);
  endproperty
  a_gap_one: assert property (p_gap_one) else $error("segment one not written");

  property p_gap_two;
    @(posedge clk) disable iff (rst)
    wr_stb && hit(addr, MRC_OFF_GAP_TWO) |=> gap_seg_two == $past(wr_data[6:0]);
  endproperty
  a_gap_two: assert property (p_gap_two) else $error("segment two not written");

  property p_rdo;
    @(posedge clk) disable iff (rst)
    rd_stb && hit(addr, MRC_OFF_MGMT) |=> rd_data[MRC_B_RDO] == $past(rdo_sync_ff[1]);
  endproperty
  a_rdo: assert property (p_rdo) else $error("rom data sample wrong");

  property p_rom;
    @(posedge clk) disable iff (rst)
    wr_stb && hit(addr, MRC_OFF_MGMT) |=> serial_rom_clock == $past(wr_data[MRC_B_RCLK])
      && serial_rom_select == $past(wr_data[MRC_B_RCS]) && rom_data_in_pin == $past(wr_data[MRC_B_RDI])
      && mdc_pin == $past(wr_data[MRC_B_MDC]);
  endproperty
  a_rom: assert property (p_rom) else $error("port pins wrong");

  property p_phy;
    @(posedge clk) disable iff (rst)
    rd_stb && hit(addr, MRC_OFF_TEST) |=> rd_data == {4'h0, $past(phy_sync1_ff)};
  endproperty
  a_phy: assert property (p_phy) else $error("phy status read wrong");

endmodule : mrc_regs

/* tb/mrc_host.sv */
// Host model: byte reads and writes on the register strobes.
// Assumes strobes taken on rising clk; drives after falling edges.
`timescale 1ns/10ps
module mrc_host
  import mrc_pkg::*;
(
  input  wire logic       clk,
  output logic      [4:0] addr,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic      [7:0] wr_data,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial
  begin
    addr    = 5'h00;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
    wr_data = 8'h00;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    addr    = a;
    wr_data = (a == MRC_OFF_TEST) ? 8'h00 : d;
    wr_stb  = 1'b1;
    @(negedge clk);
    wr_stb  = 1'b0;
    // Released data no longer shows the last byte
    wr_data = ~wr_data;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    addr   = a;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    d      = rd_valid ? rd_data : 8'hxx;
  endtask : rd
endmodule : mrc_host

/* tb/tb_mrc_regs.sv */
// Self-checking bench for the register slice.
// Assumes the host model drives the bus; bench drives pins and frame inputs.
`timescale 1ns/10ps
module tb_mrc_regs;
  import mrc_pkg::*;
  logic [4:0] addr;
  logic       wr_stb, rd_stb, rd_valid, irq_pin, frm_accept, frm_store;
  logic [7:0] wr_data, rd_data;
  logic       clk = 1'b0, rst = 1'b1, isa_bus_mode = 1'b1, irq_raw = 1'b0, frm_end = 1'b0;
  logic       frm_unicast = 0, frm_station_hit = 0, frm_multicast = 0, frm_hash_hit = 0;
  logic       frm_bcast = 0, frm_runt = 0, frm_errored = 0, rom_do = 0, mdio_i = 0;
  mrc_rxst_t  frm_status = '0;
  mrc_physt_t phy_status = '0;
  mrc_filt_t  filt_cfg;
  logic [6:0] gap_length, gap_seg_one, gap_seg_two;
  logic       rom_clk, rom_sel, rom_di, mdio_o, mdio_oe, mdc_pin;
  logic [4:0] test_ctrl;
  int         n_errors = 0, checked = 0, cycles = 0;
  // {config, unicast, station hit, multicast, hash hit, bcast, runt, errored, accept}
  localparam logic [15:0] FTAB [12] = '{
    {8'h04, 7'h04, 1'b1}, {8'h00, 7'h04, 1'b0}, {8'h24, 7'h04, 1'b1}, {8'h10, 7'h40, 1'b1},
    {8'h00, 7'h40, 1'b0}, {8'h00, 7'h60, 1'b1}, {8'h08, 7'h18, 1'b1}, {8'h08, 7'h10, 1'b0},
    {8'h04, 7'h06, 1'b0}, {8'h06, 7'h06, 1'b1}, {8'h05, 7'h05, 1'b1}, {8'h04, 7'h05, 1'b0}};

  mrc_host host (.clk(clk), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid));

  mrc_regs dut (.clk(clk), .rst(rst), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .isa_bus_mode(isa_bus_mode), .irq_raw(irq_raw),
    .irq_pin(irq_pin), .frm_end(frm_end), .frm_status(frm_status), .frm_unicast(frm_unicast),
    .frm_station_hit(frm_station_hit), .frm_multicast(frm_multicast), .frm_hash_hit(frm_hash_hit),
    .frm_bcast(frm_bcast), .frm_runt(frm_runt), .frm_errored(frm_errored), .frm_accept(frm_accept),
    .frm_store(frm_store), .filt_cfg(filt_cfg), .gap_length(gap_length), .gap_seg_one(gap_seg_one),
    .gap_seg_two(gap_seg_two), .serial_rom_clock(rom_clk), .serial_rom_select(rom_sel),
    .rom_data_in_pin(rom_di), .rom_data_out_pin(rom_do), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdc_pin(mdc_pin), .test_ctrl(test_ctrl), .phy_status(phy_status));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic summarize;
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Generous ceiling: the sequence needs well under 1000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rdchk

  task automatic t_resets;
    chk({2'b00, filt_cfg}, 8'h00);
    rdchk(MRC_OFF_GAP, 8'h15);
    rdchk(MRC_OFF_GAP_ONE, 8'h0c);
    rdchk(MRC_OFF_GAP_TWO, 8'h12);
    rdchk(5'h1f, 8'h00);
    chk({6'h00, irq_pin, mdio_oe}, 8'h00);
  endtask : t_resets

  task automatic t_gaps;
    host.wr(MRC_OFF_GAP, 8'hff);
    rdchk(MRC_OFF_GAP, 8'h7f);
    chk({1'b0, gap_length}, 8'h7f);
    host.wr(MRC_OFF_GAP_ONE, 8'h80);
    host.wr(MRC_OFF_GAP_TWO, 8'h55);
    rdchk(MRC_OFF_GAP_ONE, 8'h00);
    rdchk(MRC_OFF_GAP_TWO, 8'h55);
    chk({1'b0, gap_seg_one}, 8'h00);
    chk({1'b0, gap_seg_two}, 8'h55);
  endtask : t_gaps

  task automatic t_mgmt;
    host.wr(MRC_OFF_MGMT, 8'hb9);
    chk({2'b00, rom_clk, rom_di, rom_sel, mdio_o, mdio_oe, mdc_pin}, 8'h3f);
    host.wr(MRC_OFF_MGMT, 8'h21);
    chk({2'b00, rom_clk, rom_di, rom_sel, mdio_o, mdio_oe, mdc_pin}, 8'h13);
    host.wr(MRC_OFF_MGMT, 8'h90);
    chk({2'b00, rom_clk, rom_di, rom_sel, mdio_o, mdio_oe, mdc_pin}, 8'h2a);
    host.wr(MRC_OFF_MGMT, 8'h02);
    rom_do = 1'b1;
    mdio_i = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h00, mdio_oe}, 8'h00);
    rdchk(MRC_OFF_MGMT, 8'h46);
  endtask : t_mgmt

  task automatic t_irq;
    for (int i = 0; i < 8; i++)
    begin
      isa_bus_mode = i[1];
      irq_raw      = i[2];
      host.wr(MRC_OFF_RX_CFG, {1'b0, i[0], 6'h00});
      @(negedge clk);
      chk({7'h00, irq_pin}, {7'h00, i[2] ^ (i[1] ^ i[0])});
    end
  endtask : t_irq

  task automatic t_filter;
    logic [15:0] e;
    for (int i = 0; i < 12; i++)
    begin
      e = FTAB[i];
      host.wr(MRC_OFF_RX_CFG, e[15:8] | 8'h80);
      {frm_unicast, frm_station_hit, frm_multicast, frm_hash_hit, frm_bcast, frm_runt, frm_errored} = e[7:1];
      #1;
      chk({7'h00, frm_accept}, {7'h00, e[0]});
      chk({7'h00, frm_store}, {7'h00, e[0] & ~e[13]});
      chk({2'b00, filt_cfg.watch_only_mode, filt_cfg.accept_all_unicast, filt_cfg.accept_group_cast,
        filt_cfg.accept_bcast, filt_cfg.accept_short_frames, filt_cfg.keep_errored_frames},
        {2'b00, e[13], e[12], e[11], e[10], e[9], e[8]});
    end
  endtask : t_filter

  task automatic t_status;
    for (int i = 0; i < 2; i++)
    begin
      frm_status = i[0] ? 7'h2a : 7'h55;
      frm_end    = 1'b1;
      @(negedge clk);
      frm_end    = 1'b0;
      rdchk(MRC_OFF_RX_CFG, i[0] ? 8'h2a : 8'h55);
    end
  endtask : t_status

  task automatic t_phy;
    host.wr(MRC_OFF_TEST, 8'h00);
    chk({3'b000, test_ctrl}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      phy_status = (i == 1) ? 4'hb : ((i == 2) ? 4'h4 : 4'ha);
      repeat (4) @(negedge clk);
      rdchk(MRC_OFF_TEST, {4'h0, phy_status});
    end
  endtask : t_phy

  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_resets();
    t_gaps();
    t_mgmt();
    t_irq();
    t_filter();
    t_status();
    t_phy();
    // Mid-run reset must bring written registers back
    irq_raw = 1'b0;
    rst     = 1'b1;
    repeat (2) @(negedge clk);
    rst     = 1'b0;
    t_resets();
    summarize();
  end
endmodule : tb_mrc_regs
